// file: ssb_pkg.sv
// package: register map, field positions, reset values and axi response codes
package ssb_pkg;
	// ============================================================
	// register map (byte addresses, one word each)
	localparam logic [5:0] OFF_STATUS   = 6'h00;
	localparam logic [5:0] OFF_CONTROL  = 6'h04;
	localparam logic [5:0] OFF_MODE     = 6'h08;
	localparam logic [5:0] OFF_DIVISOR1 = 6'h0c;
	localparam logic [5:0] OFF_DIVISOR2 = 6'h10;
	localparam logic [5:0] OFF_IRQ_STAT = 6'h14;
	localparam logic [5:0] OFF_IRQ_MASK = 6'h18;
	localparam logic [5:0] OFF_RXDATA   = 6'h1c;
	localparam logic [5:0] OFF_TXDATA   = 6'h20;
	// ============================================================
	// status fields
	localparam int BIT_TRANSMIT_EMPTY_FLAG  = 7;
	localparam int BIT_RECEIVE_FULL_FLAG  = 6;
	localparam int BIT_PER   = 3;
	localparam int BIT_TRANSMIT_END_FLAG  = 2;
	localparam int BIT_MPRX  = 1;
	localparam int BIT_MPTX  = 0;
	// control fields
	localparam int BIT_TE    = 5;
	localparam int BIT_RE    = 4;
	// mode fields
	localparam int BIT_SYNC  = 7;
	localparam int BIT_PAREN = 5;
	localparam int BIT_ODD   = 4;
	localparam int BIT_MP    = 2;
	localparam int BIT_CKS_HI = 1;
	localparam int BIT_CKS_LO = 0;
	// ============================================================
	// reset values
	localparam logic [7:0] RST_STATUS  = 8'h84;
	localparam logic [7:0] RST_DIVISOR = 8'hff;
	localparam logic [7:0] RST_ZERO    = 8'h00;
	// interrupt bits: 0 parity error, 1 transmit end, 2 receive full
	localparam int IRQ_W = 3;
	// async: 64 x 2^(2n-1) = 32 x 4^n clocks per bit; the prescaler gives the 4^n
	localparam int ASYNC_TICKS = 32;
	localparam logic [1:0] AXI_OKAY   = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : ssb_pkg

// file: ssb_rate_gen.sv
// bit-rate generator: prescaler chosen by two select bits, then divisor+1
module ssb_rate_gen
	import ssb_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic [1:0] prescale_i,
	input  wire logic [7:0] divisor_i,
	output logic            tick_o
);
	typedef struct packed {
		logic [5:0] pre;
		logic [7:0] cnt;
		logic       tick;
	} ssb_rate_t;
	ssb_rate_t s, next_s;
	logic pre_hit;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		// prescale 1, 4, 16, 64 system clocks
		unique case (prescale_i)
			2'd0: pre_hit = 1'b1;
			2'd1: pre_hit = (s.pre[1:0] == 2'h3);
			2'd2: pre_hit = (s.pre[3:0] == 4'hf);
			2'd3: pre_hit = (s.pre == 6'h3f);
		endcase
		next_s.pre = s.pre + 6'h01;
		if (pre_hit) begin
			next_s.pre = 6'h00;
			// divisor+1 prescaled clocks per base tick
			if (s.cnt >= divisor_i) begin
				next_s.cnt  = 8'h00;
				next_s.tick = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			s <= '0;
		else
			s <= next_s;
	end
	assign tick_o = s.tick;
endmodule : ssb_rate_gen

// file: ssb_channel.sv
// serial channel core: status flags, divisors, tx/rx engines, axi4-lite slave
//
// Overview of operation
// - parity mismatch on receive sets parity error
// - bad parity still stores byte, no full flag
// - parity error halts receive; sync halts transmit too
// - parity error clears: reset/standby or read-then-zero
// - receive enable off keeps parity error; resets zero
// - last bit out with empty set: transmit end
// - transmit end one on reset, standby, enable off
// - transmit end clears on empty-clear or dma write
// - transmit end read-only, writes ignored
// - multiprocessor receive bit captured, read-only
// - receive enable off keeps multiprocessor bit
// - multiprocessor tx bit only in async mp
// - bit rate from divisor and prescale select
// - divisor always accessible, ones on reset/standby
// - two rate generators, independent divisors, chan_sel_i picks one
// - good byte sets receive full flag
module ssb_channel
	import ssb_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        standby_i,
	input  wire logic        chan_sel_i,
	input  wire logic        rxd_i,
	output logic             txd_o,
	input  wire logic        dma_tx_wr_i,
	input  wire logic [7:0]  dma_tx_data_i,
	output logic             irq_o,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SHIFT = 3'b010,
		TX_STOP = 3'b100
	} ssb_tx_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_SHIFT = 3'b010,
		RX_DONE = 3'b100
	} ssb_rx_t;

	typedef struct packed {
		logic [7:0]        status;
		logic [7:0]        control;
		logic [7:0]        mode;
		logic [1:0][7:0]   divisor;
		logic [IRQ_W-1:0]  irq_stat;
		logic [IRQ_W-1:0]  irq_mask;
		logic [7:0]        tx_byte;
		logic [7:0]        rx_byte;
		logic              per_seen;
		logic              transmit_empty_flag_seen;
		ssb_tx_t           tx_st;
		logic [10:0]       tx_sh;
		logic [3:0]        tx_cnt;
		logic [5:0]        tx_ph;
		ssb_rx_t           rx_st;
		logic [10:0]       rx_sh;
		logic [3:0]        rx_cnt;
		logic [5:0]        rx_ph;
		logic              txd;
		logic              irq;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [5:0]        awaddr;
		logic              aw_have;
		logic [31:0]       wdata;
		logic              w_have;
	} ssb_state_t;
	ssb_state_t s, next_s;

	logic [1:0] tick;
	logic       rtick;
	logic       sync_mode;
	logic       mp_on;
	logic       par_on;
	logic [3:0] frame_len;
	logic       do_wr;
	logic       do_rd;
	logic       ok_wr;
	logic [31:0] rd_val;
	logic       rx_par;
	logic       rx_mp;
	logic [7:0] rx_data;

	// ============================================================
	// two independent rate generators
	for (genvar g = 0; g < 2; g++) begin : g_rate
		ssb_rate_gen u_rate (
			.clk_sys_i  (clk_sys_i),
			.rst_n_i    (rst_n_i),
			.prescale_i ({s.mode[BIT_CKS_HI], s.mode[BIT_CKS_LO]}),
			.divisor_i  (s.divisor[g]),
			.tick_o     (tick[g])
		);
	end
	assign rtick = tick[chan_sel_i];

	// ============================================================
	// frame format
	always_comb begin
		sync_mode = s.mode[BIT_SYNC];
		mp_on     = s.mode[BIT_MP] && !sync_mode;
		par_on    = s.mode[BIT_PAREN] && !sync_mode && !mp_on;
		// data bits + optional parity/mp bit + stop
		frame_len = 4'd9 + {3'd0, (par_on || mp_on)};
		// frame_len+1 samples land in the top of rx_sh, start bit lowest
		rx_data   = (par_on || mp_on) ? s.rx_sh[8:1] : s.rx_sh[9:2];
		rx_par    = s.rx_sh[9];
		rx_mp     = s.rx_sh[9];
	end

	// ============================================================
	// register access
	always_comb begin
		do_wr = s.aw_have && s.w_have && !s.bvalid;
		do_rd = s_axi_arvalid && s.arready;
		ok_wr = 1'b1;
		unique case (s.awaddr)
			OFF_STATUS, OFF_CONTROL, OFF_MODE, OFF_DIVISOR1, OFF_DIVISOR2,
			OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_TXDATA, OFF_RXDATA: ok_wr = 1'b1;
			default: ok_wr = 1'b0;
		endcase
		rd_val = 32'h0;
		unique case (s_axi_araddr[5:0])
			OFF_STATUS:   rd_val = {24'h0, s.status};
			OFF_CONTROL:  rd_val = {24'h0, s.control};
			OFF_MODE:     rd_val = {24'h0, s.mode};
			OFF_DIVISOR1: rd_val = {24'h0, s.divisor[0]};
			OFF_DIVISOR2: rd_val = {24'h0, s.divisor[1]};
			OFF_IRQ_STAT: rd_val = {29'h0, s.irq_stat};
			OFF_IRQ_MASK: rd_val = {29'h0, s.irq_mask};
			OFF_RXDATA:   rd_val = {24'h0, s.rx_byte};
			OFF_TXDATA:   rd_val = {24'h0, s.tx_byte};
			default:      rd_val = 32'h0;
		endcase
	end

	// ============================================================
	// next state
	always_comb begin
		next_s = s;
		// axi handshakes
		if (s_axi_awvalid && s.awready) begin
			next_s.awaddr  = s_axi_awaddr[5:0];
			next_s.aw_have = 1'b1;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.wdata  = s_axi_wdata;
			next_s.w_have = 1'b1;
		end
		next_s.awready = !next_s.aw_have;
		next_s.wready  = !next_s.w_have;
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		next_s.arready = !next_s.rvalid && !do_rd;
		if (do_rd) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rd_val;
			next_s.rresp  = (s_axi_araddr[5:0] > OFF_TXDATA ||
				s_axi_araddr[1:0] != 2'b00) ? AXI_SLVERR : AXI_OKAY;
			// arm read-then-zero clears only on a one seen
			if (s_axi_araddr[5:0] == OFF_STATUS) begin
				next_s.per_seen  = s.status[BIT_PER];
				next_s.transmit_empty_flag_seen = s.status[BIT_TRANSMIT_EMPTY_FLAG];
			end
		end

		if (do_wr) begin
			next_s.aw_have = 1'b0;
			next_s.w_have  = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready  = 1'b1;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = ok_wr ? AXI_OKAY : AXI_SLVERR;
			if (s_axi_wstrb[0]) begin
				unique case (s.awaddr)
					OFF_STATUS: begin
						if (s.per_seen && !s.wdata[BIT_PER]) begin
							next_s.status[BIT_PER] = 1'b0;
							next_s.per_seen = 1'b0;
						end
						if (s.transmit_empty_flag_seen && !s.wdata[BIT_TRANSMIT_EMPTY_FLAG]) begin
							next_s.status[BIT_TRANSMIT_EMPTY_FLAG] = 1'b0;
							next_s.status[BIT_TRANSMIT_END_FLAG] = 1'b0;
							next_s.transmit_empty_flag_seen = 1'b0;
						end
						// transmit_end_flag, mp rx bit ignore writes
						next_s.status[BIT_MPTX] = s.wdata[BIT_MPTX];
					end
					OFF_CONTROL: begin
						next_s.control = s.wdata[7:0];
						if (!s.wdata[BIT_TE])
							next_s.status[BIT_TRANSMIT_END_FLAG] = 1'b1;
						// receive enable off leaves per and mp rx
					end
					OFF_MODE:     next_s.mode = s.wdata[7:0];
					OFF_DIVISOR1: next_s.divisor[0] = s.wdata[7:0];
					OFF_DIVISOR2: next_s.divisor[1] = s.wdata[7:0];
					OFF_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~s.wdata[IRQ_W-1:0];
					OFF_IRQ_MASK: next_s.irq_mask = s.wdata[IRQ_W-1:0];
					OFF_TXDATA:   next_s.tx_byte = s.wdata[7:0];
					default: ;
				endcase
			end
		end

		// dma write of transmit byte clears empty and end
		if (dma_tx_wr_i) begin
			next_s.tx_byte = dma_tx_data_i;
			next_s.status[BIT_TRANSMIT_EMPTY_FLAG] = 1'b0;
			next_s.status[BIT_TRANSMIT_END_FLAG] = 1'b0;
		end

		// transmitter: sync mode halts on parity error
		if (rtick) begin
			next_s.tx_ph = s.tx_ph + 6'h01;
			if (s.tx_ph == 6'(ASYNC_TICKS - 1) || sync_mode) begin
				next_s.tx_ph = 6'h00;
				unique case (s.tx_st)
					TX_IDLE: begin
						if (s.control[BIT_TE] && !s.status[BIT_TRANSMIT_EMPTY_FLAG] &&
							!(sync_mode && s.status[BIT_PER])) begin
							// mp bit appended only in async mp
							next_s.tx_sh = {1'b1,
								mp_on ? s.status[BIT_MPTX] : (s.mode[BIT_ODD] ^ ^s.tx_byte),
								s.tx_byte, 1'b0};
							if (!(par_on || mp_on))
								next_s.tx_sh[9] = 1'b1;
							next_s.status[BIT_TRANSMIT_EMPTY_FLAG] = 1'b1;
							next_s.status[BIT_TRANSMIT_END_FLAG] = 1'b0;
							next_s.tx_cnt = 4'd0;
							next_s.tx_st  = TX_SHIFT;
						end
					end
					TX_SHIFT: begin
						next_s.txd   = s.tx_sh[0];
						next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
						next_s.tx_cnt = s.tx_cnt + 4'd1;
						if (s.tx_cnt == frame_len)
							next_s.tx_st = TX_STOP;
					end
					TX_STOP: begin
						next_s.txd   = 1'b1;
						next_s.tx_st = TX_IDLE;
						if (s.status[BIT_TRANSMIT_EMPTY_FLAG]) begin
							next_s.status[BIT_TRANSMIT_END_FLAG] = 1'b1;
							next_s.irq_stat[1] = 1'b1;
						end
					end
				endcase
			end
		end

		// receiver: mid-bit sampling, halted while parity error set
		if (rtick) begin
			next_s.rx_ph = s.rx_ph + 6'h01;
			unique case (s.rx_st)
				RX_IDLE: begin
					next_s.rx_ph = 6'h00;
					if (s.control[BIT_RE] && !s.status[BIT_PER] && !rxd_i) begin
						next_s.rx_cnt = 4'd0;
						next_s.rx_st  = RX_SHIFT;
					end
				end
				RX_SHIFT: begin
					if (s.rx_ph == 6'(ASYNC_TICKS / 2 - 1)) begin
						next_s.rx_sh  = {rxd_i, s.rx_sh[10:1]};
						next_s.rx_cnt = s.rx_cnt + 4'd1;
						if (s.rx_cnt == frame_len)
							next_s.rx_st = RX_DONE;
					end
					if (s.rx_ph == 6'(ASYNC_TICKS - 1))
						next_s.rx_ph = 6'h00;
				end
				RX_DONE: begin
					next_s.rx_st = RX_IDLE;
					// align: frame shifted in lsb-first from the top
					next_s.rx_byte = rx_data;
					if (mp_on)
						next_s.status[BIT_MPRX] = rx_mp;
					if (par_on && (^rx_data ^ rx_par) != s.mode[BIT_ODD]) begin
						next_s.status[BIT_PER] = 1'b1;
						next_s.irq_stat[0] = 1'b1;
					end else begin
						next_s.status[BIT_RECEIVE_FULL_FLAG] = 1'b1;
						next_s.irq_stat[2] = 1'b1;
					end
				end
				default: next_s.rx_st = RX_IDLE;
			endcase
		end
		// a byte landing in the same cycle keeps the full flag if irq bit 2 was clear: set wins
		if (do_rd && s_axi_araddr[5:0] == OFF_RXDATA && !(next_s.irq_stat[2] && !s.irq_stat[2]))
			next_s.status[BIT_RECEIVE_FULL_FLAG] = 1'b0;
		next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
	end

	// ============================================================
	// state register; standby acts like reset on flags and divisors
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s          <= '0;
			s.status   <= RST_STATUS;
			s.divisor  <= {RST_DIVISOR, RST_DIVISOR};
			s.tx_st    <= TX_IDLE;
			s.rx_st    <= RX_IDLE;
			s.txd      <= 1'b1;
			s.awready  <= 1'b1;
			s.wready   <= 1'b1;
			s.arready  <= 1'b1;
		end else begin
			s <= next_s;
			if (standby_i) begin
				s.status  <= RST_STATUS;
				s.divisor <= {RST_DIVISOR, RST_DIVISOR};
				s.tx_st   <= TX_IDLE;
				s.rx_st   <= RX_IDLE;
			end
		end
	end

	assign txd_o         = s.txd;
	assign irq_o         = s.irq;
	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;

	// ============================================================
	// checks
	a_divisor_reset: assert property (@(posedge clk_sys_i)
		!rst_n_i |=> s.divisor[0] == RST_DIVISOR && s.divisor[1] == RST_DIVISOR)
		else $error("divisor not all ones after reset");
	a_transmit_end_flag_te_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		do_wr && s.awaddr == OFF_CONTROL && s_axi_wstrb[0] && !s.wdata[BIT_TE]
		&& !dma_tx_wr_i && !standby_i |=> s.status[BIT_TRANSMIT_END_FLAG])
		else $error("transmit end not set on enable off");
	a_per_no_full: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(s.status[BIT_PER]) |-> !$rose(s.status[BIT_RECEIVE_FULL_FLAG]))
		else $error("full flag set with parity error");
	a_per_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s.status[BIT_PER] && !standby_i && !(do_wr && s.awaddr == OFF_STATUS)
		|=> s.status[BIT_PER])
		else $error("parity error dropped without clear");
	a_rx_halt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s.status[BIT_PER] && s.rx_st == RX_IDLE |=> s.rx_st == RX_IDLE)
		else $error("receiver restarted with parity error");
	a_transmit_end_flag_ro: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(s.status[BIT_TRANSMIT_END_FLAG]) |-> $past(dma_tx_wr_i) || $past(do_wr)
		|| $past(s.tx_st) == TX_IDLE)
		else $error("transmit end cleared without cause");
	a_mprx_ro: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$changed(s.status[BIT_MPRX]) |-> $past(s.rx_st) == RX_DONE || $past(standby_i))
		else $error("mp receive bit changed outside capture");
	a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		##1 irq_o == |($past(next_s.irq_stat & next_s.irq_mask)))
		else $error("interrupt level mismatch");
endmodule : ssb_channel

// file: ssb_remote_dev.sv
// remote serial device model: sends frames on rxd, captures frames from txd
module ssb_remote_dev (
	input  wire logic clk_sys_i,
	input  wire logic line_i,
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int         bit_clks = 32;
	int         got_count = 0;
	logic [7:0] got_byte;
	logic       got_extra;
	initial line_o = 1'b1;

	task automatic wait_bits(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : wait_bits

	// ============================================================
	// sender: start, data lsb first, optional extra bit, stop
	task automatic send(input logic [7:0] d, input logic has_x, input logic x);
		line_o <= 1'b0;
		wait_bits(bit_clks);
		for (int i = 0; i < 8; i++) begin
			line_o <= d[i];
			wait_bits(bit_clks);
		end
		if (has_x) begin
			line_o <= x;
			wait_bits(bit_clks);
		end
		line_o <= 1'b1;
		wait_bits(2 * bit_clks);
	endtask : send

	// ============================================================
	// receiver: samples mid-bit; the bit after the data is kept apart
	always begin
		@(negedge line_i);
		wait_bits(bit_clks / 2);
		for (int i = 0; i < 8; i++) begin
			wait_bits(bit_clks);
			got_byte[i] = line_i;
		end
		wait_bits(bit_clks);
		got_extra = line_i;
		got_count++;
		wait_bits(bit_clks / 2);
	end
endmodule : ssb_remote_dev

// file: tb.sv
// testbench for the serial status and bit-rate block
module tb
	import ssb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic wr; logic [5:0] a; logic [7:0] d; logic [1:0] r;} ssb_row_t;
	logic        clk_sys_i, rst_n_i, standby_i, chan_sel_i, rxd_i, txd_o, dma_tx_wr_i, irq_o;
	logic [7:0]  dma_tx_data_i;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          n_mismatch = 0;
	int          checks = 0;
	logic [7:0]  mode_tab [3] = '{8'h04, 8'h04, 8'h00};
	logic [2:0]  extra_tab = 3'b110;

	ssb_row_t rows [11] = '{
		'{1'b0, OFF_STATUS, 8'h84, AXI_OKAY},
		'{1'b0, OFF_DIVISOR1, 8'hff, AXI_OKAY},
		'{1'b0, OFF_DIVISOR2, 8'hff, AXI_OKAY},
		'{1'b1, OFF_DIVISOR1, 8'h00, AXI_OKAY},
		'{1'b1, OFF_DIVISOR2, 8'h01, AXI_OKAY},
		'{1'b0, OFF_DIVISOR1, 8'h00, AXI_OKAY},
		'{1'b0, OFF_DIVISOR2, 8'h01, AXI_OKAY},
		'{1'b0, OFF_CONTROL, 8'h00, AXI_OKAY},
		'{1'b0, OFF_IRQ_MASK, 8'h00, AXI_OKAY},
		'{1'b0, 6'h24, 8'h00, AXI_SLVERR},
		'{1'b1, 6'h24, 8'h00, AXI_SLVERR}
	};

	ssb_channel dut_u (.clk_sys_i, .rst_n_i, .standby_i, .chan_sel_i, .rxd_i, .txd_o,
		.dma_tx_wr_i, .dma_tx_data_i, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	ssb_remote_dev partner_u (.clk_sys_i, .line_i(txd_o), .line_o(rxd_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	// ============================================================
	// checking and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	task automatic axi_wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge clk_sys_i);
		s_axi_awaddr <= {26'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys_i);
		s_axi_araddr <= {26'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
	endtask : wr

	// compares only the bits under the mask
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		chk(d & {24'h0, m}, {24'h0, e});
	endtask : rd_chk

	task automatic dma(input logic [7:0] d);
		@(posedge clk_sys_i);
		dma_tx_wr_i <= 1'b1;
		dma_tx_data_i <= d;
		@(posedge clk_sys_i);
		dma_tx_wr_i <= 1'b0;
	endtask : dma

	task automatic tx_done(input int n);
		wait (partner_u.got_count == n);
		repeat (partner_u.bit_clks + 16) @(posedge clk_sys_i);
	endtask : tx_done

	// ============================================================
	// watchdog: about 4k cycles expected
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		{rst_n_i, standby_i, chan_sel_i, dma_tx_wr_i, dma_tx_data_i} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_wr(rows[i].a, rows[i].d, r);
			end else begin
				axi_rd(rows[i].a, d, r);
				chk(d, {24'h0, rows[i].d});
			end
			chk({30'h0, r}, {30'h0, rows[i].r});
		end
		$display("test register table done");
		wr(OFF_IRQ_MASK, 8'h02);
		wr(OFF_CONTROL, 8'h20);
		wr(OFF_TXDATA, 8'h3c);
		rd_chk(OFF_STATUS, 8'h84, 8'h84);
		wr(OFF_STATUS, 8'h04);
		rd_chk(OFF_STATUS, 8'h04, 8'h00);
		tx_done(1);
		chk({24'h0, partner_u.got_byte}, 32'h3c);
		rd_chk(OFF_STATUS, 8'h84, 8'h84);
		chk({31'h0, irq_o}, 32'h1);
		wr(OFF_IRQ_STAT, 8'h02);
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h0);
		$display("test cpu transmit done");
		partner_u.bit_clks = 64;
		chan_sel_i <= 1'b1;
		dma(8'h5a);
		rd_chk(OFF_STATUS, 8'h04, 8'h00);
		tx_done(2);
		chk({24'h0, partner_u.got_byte}, 32'h5a);
		partner_u.bit_clks = 32;
		chan_sel_i <= 1'b0;
		$display("test dma transmit on channel two done");
		// mp format with bit 0 then 1, then plain format where only the stop bit follows
		for (int k = 0; k < 3; k++) begin
			wr(OFF_MODE, mode_tab[k]);
			wr(OFF_STATUS, {7'h40, k[0]});
			dma(8'hc3);
			tx_done(3 + k);
			chk({31'h0, partner_u.got_extra}, {31'h0, extra_tab[k]});
		end
		dma(8'hff);
		wr(OFF_CONTROL, 8'h00);
		rd_chk(OFF_STATUS, 8'h04, 8'h04);
		$display("test multiprocessor transmit and enable off done");
		// even parity on 0x81 wants 0: send 1
		wr(OFF_MODE, 8'h20);
		wr(OFF_CONTROL, 8'h10);
		wr(OFF_IRQ_MASK, 8'h00);
		wr(OFF_IRQ_STAT, 8'h07);
		partner_u.send(8'h81, 1'b1, 1'b1);
		rd_chk(OFF_STATUS, 8'h48, 8'h08);
		rd_chk(OFF_RXDATA, 8'hff, 8'h81);
		chk({31'h0, irq_o}, 32'h0);
		partner_u.send(8'h11, 1'b1, 1'b0);
		rd_chk(OFF_RXDATA, 8'hff, 8'h81);
		wr(OFF_IRQ_MASK, 8'h01);
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h1);
		wr(OFF_CONTROL, 8'h00);
		rd_chk(OFF_STATUS, 8'h08, 8'h08);
		wr(OFF_STATUS, 8'hf6);
		rd_chk(OFF_STATUS, 8'h08, 8'h00);
		wr(OFF_MODE, 8'h30);
		wr(OFF_CONTROL, 8'h10);
		partner_u.send(8'h81, 1'b1, 1'b1);
		rd_chk(OFF_STATUS, 8'h48, 8'h40);
		rd_chk(OFF_RXDATA, 8'hff, 8'h81);
		rd_chk(OFF_STATUS, 8'h40, 8'h00);
		$display("test parity receive done");
		wr(OFF_MODE, 8'h04);
		partner_u.send(8'h66, 1'b1, 1'b1);
		rd_chk(OFF_STATUS, 8'h02, 8'h02);
		wr(OFF_STATUS, 8'h80);
		rd_chk(OFF_STATUS, 8'h02, 8'h02);
		wr(OFF_CONTROL, 8'h00);
		rd_chk(OFF_STATUS, 8'h02, 8'h02);
		$display("test multiprocessor receive done");
		@(posedge clk_sys_i);
		standby_i <= 1'b1;
		@(posedge clk_sys_i);
		standby_i <= 1'b0;
		rd_chk(OFF_STATUS, 8'hff, 8'h84);
		rd_chk(OFF_DIVISOR2, 8'hff, 8'hff);
		$display("test standby done");
		tally_and_finish();
	end
endmodule : tb
